/* design/ctc_pkg.sv */
// Constants and carriers for the timer compare and status register block
package ctc_pkg;

    // Register numbers on the system_coprocessor register port
    localparam logic [4:0]  CTC_REG_COUNT         = 5'h09;
    localparam logic [4:0]  CTC_REG_COMPARE       = 5'h0B;
    localparam logic [4:0]  CTC_REG_STATUS        = 5'h0C;

    // processor_mode_control field positions
    localparam int          CTC_COP_USABLE_LSB    = 28;
    localparam int          CTC_REDUCED_POWER_BIT = 27;
    localparam int          CTC_USER_SWAP_BIT     = 25;
    localparam int          CTC_BOOT_VECTOR_BIT   = 22;
    localparam int          CTC_TLB_SHUTDOWN_BIT  = 21;
    localparam int          CTC_SOFT_RESET_BIT    = 20;
    localparam int          CTC_NMI_ENTRY_BIT     = 19;
    localparam int          CTC_INT_MASK_LSB      = 8;
    localparam int          CTC_USER_MODE_BIT     = 4;
    localparam int          CTC_ERROR_LEVEL_BIT   = 2;
    localparam int          CTC_EXC_LEVEL_BIT     = 1;
    localparam int          CTC_INT_ENABLE_BIT    = 0;

    // Bits that a plain write stores
    localparam logic [31:0] CTC_STATUS_WR_MASK    = 32'hFA60FF17;
    // Bits that a write may only clear
    localparam logic [31:0] CTC_STATUS_CLR_MASK   = 32'h00180000;
    // Cold reset: boot_vector_sel and error_level set, all else zero
    localparam logic [31:0] CTC_STATUS_RESET      = 32'h00400004;
    localparam logic [31:0] CTC_COMPARE_RESET     = 32'h00000000;
    localparam logic [31:0] CTC_COUNT_RESET       = 32'h00000000;
    localparam logic [31:0] CTC_ZERO_WORD         = 32'h00000000;

    typedef struct packed {
        logic        en;
        logic [4:0]  num;
        logic [31:0] data;
    } ctc_wr_req_t;

    typedef struct packed {
        logic        en;
        logic [4:0]  num;
    } ctc_rd_req_t;

    // Exception and event pulses from the pipeline
    typedef struct packed {
        logic soft_reset_take;
        logic nmi_take;
        logic exception_take;
        logic tlb_shutdown_detect;
    } ctc_events_t;

endpackage

/* design/ctc_count_timer.sv */
// Free-running interval counter stepping every second core clock
`timescale 1ns/1ps
module ctc_count_timer (
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic        load_en,
    input  wire logic [31:0] load_value,
    output logic      [31:0] count_reg,
    output logic             step_reg
);
    import ctc_pkg::*;

    logic phase_reg;

    // Step on every other clock, independent of the pipeline
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            phase_reg <= 1'b0;
        end else begin
            phase_reg <= ~phase_reg;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            count_reg <= CTC_COUNT_RESET;
        end else if (load_en) begin
            count_reg <= load_value;
        end else if (phase_reg) begin
            count_reg <= count_reg + 32'h00000001;
        end
    end

    // Marks the cycle in which a new count value is visible
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            step_reg <= 1'b0;
        end else begin
            step_reg <= load_en | phase_reg;
        end
    end

endmodule // ctc_count_timer

/* design/ctc_timer_status.sv */
// Timer compare, count and processor mode control registers
//
// Function
// - Compare value changes only by software write.
// - Timer interrupt holds until compare is written; write clears it unless a match lands in the same cycle.
// - Compare is fully readable and writable, no defined reset meaning.
// - Global enable needs int_enable set, both levels and debug clear.
// - Debug overrides; user needs user bit, no levels; else kernel.
// - Usability bits gate coprocessors; coprocessor 0 usable in kernel.
// - Usability bits for absent coprocessors 1 to 3 remain settable.
// - Reduced power bit drives its output; writes set or clear it, cold reset clears it, soft reset does not.
// - Reserved status bits read zero and ignore writes.
// - Byte order swap applies to user mode references only.
// - Boot vector select picks bootstrap vectors, resets to one.
// - Soft reset flag set on soft reset entry; software only clears.
// - NMI entry flag set on NMI entry; software only clears.
// - Interrupt taken if enabled and some line is unmasked and pending.
// - Count steps once every two core clocks regardless of pipeline.
// - Error level set on reset, soft reset or NMI; reads one after reset.
// - Exception level set on every exception taken other than reset, soft reset or NMI.
// - Interrupt enable is the master enable for all interrupts.
`timescale 1ns/1ps
module ctc_timer_status (
    input  wire logic                 clock,
    input  wire logic                 rst_b,
    input  wire ctc_pkg::ctc_wr_req_t wr_req,
    input  wire ctc_pkg::ctc_rd_req_t rd_req,
    input  wire ctc_pkg::ctc_events_t events,
    input  wire logic                 debug_mode_bit,
    input  wire logic [7:0]           int_pending,
    output logic      [31:0]          rd_data_reg,
    output logic                      rd_valid_reg,
    output logic                      timer_irq_out,
    output logic                      reduced_power_out,
    output logic                      int_global_en_reg,
    output logic                      take_interrupt_reg,
    output logic                      debug_mode_reg,
    output logic                      user_mode_reg,
    output logic                      kernel_mode_reg,
    output logic      [3:0]           cop_access_reg,
    output logic                      user_swap_active_reg,
    output logic                      boot_vector_reg
);
    import ctc_pkg::*;

    logic [31:0] compare_reg;
    logic [31:0] status_reg;
    logic [31:0] status_next;
    logic [31:0] count_value;
    logic        count_step;
    logic        wr_compare;
    logic        wr_status;
    logic        wr_count;
    logic        user_next;
    logic        kernel_next;
    logic        genable_next;
    logic [7:0]  pend_masked;

    assign wr_compare = wr_req.en && (wr_req.num == CTC_REG_COMPARE);
    assign wr_status  = wr_req.en && (wr_req.num == CTC_REG_STATUS);
    assign wr_count   = wr_req.en && (wr_req.num == CTC_REG_COUNT);

    ctc_count_timer u_count (
        .clock      (clock),
        .rst_b      (rst_b),
        .load_en    (wr_count),
        .load_value (wr_req.data),
        .count_reg  (count_value),
        .step_reg   (count_step)
    );

    // Compare holds its value between software writes
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            compare_reg <= CTC_COMPARE_RESET;
        end else if (wr_compare) begin
            compare_reg <= wr_req.data;
        end
    end

    // Sticky timer interrupt; a match in the write cycle wins
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            timer_irq_out <= 1'b0;
        end else if (count_step && (count_value == compare_reg)) begin
            timer_irq_out <= 1'b1;
        end else if (wr_compare) begin
            timer_irq_out <= 1'b0;
        end
    end

    // Status next value: software write, then hardware events on top
    always_comb begin
        status_next = status_reg;
        if (wr_status) begin
            // Masked bits take the write; reserved bits stay zero
            status_next = (status_reg & ~CTC_STATUS_WR_MASK)
                | (wr_req.data & CTC_STATUS_WR_MASK);
            // Entry flags: a written one keeps, a written zero clears
            status_next = status_next & ~CTC_STATUS_CLR_MASK;
            status_next = status_next
                | (status_reg & wr_req.data & CTC_STATUS_CLR_MASK);
        end
        if (events.tlb_shutdown_detect) begin
            status_next[CTC_TLB_SHUTDOWN_BIT] = 1'b1;
        end
        if (events.exception_take) begin
            status_next[CTC_EXC_LEVEL_BIT] = 1'b1;
        end
        if (events.soft_reset_take) begin
            status_next[CTC_ERROR_LEVEL_BIT] = 1'b1;
            status_next[CTC_BOOT_VECTOR_BIT] = 1'b1;
            status_next[CTC_SOFT_RESET_BIT]  = 1'b1;
            status_next[CTC_NMI_ENTRY_BIT]   = 1'b0;
        end
        if (events.nmi_take) begin
            status_next[CTC_ERROR_LEVEL_BIT] = 1'b1;
            status_next[CTC_BOOT_VECTOR_BIT] = 1'b1;
            status_next[CTC_NMI_ENTRY_BIT]   = 1'b1;
            status_next[CTC_SOFT_RESET_BIT]  = 1'b0;
        end
    end

    // Cold reset only; soft reset leaves reduced power alone
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            status_reg <= CTC_STATUS_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    // Mode decode on the value being stored
    always_comb begin
        user_next    = !debug_mode_bit
                     && status_next[CTC_USER_MODE_BIT]
                     && !status_next[CTC_EXC_LEVEL_BIT]
                     && !status_next[CTC_ERROR_LEVEL_BIT];
        kernel_next  = !debug_mode_bit && !user_next;
        genable_next = status_next[CTC_INT_ENABLE_BIT]
                     && !status_next[CTC_EXC_LEVEL_BIT]
                     && !status_next[CTC_ERROR_LEVEL_BIT]
                     && !debug_mode_bit;
        pend_masked  = status_next[CTC_INT_MASK_LSB +: 8]
                     & int_pending;
    end

    // Operating mode, one-hot across debug, user and kernel
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            debug_mode_reg  <= 1'b0;
            user_mode_reg   <= 1'b0;
            kernel_mode_reg <= 1'b1;
        end else begin
            debug_mode_reg  <= debug_mode_bit;
            user_mode_reg   <= user_next;
            kernel_mode_reg <= kernel_next;
        end
    end

    // Global enable and the take decision
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            int_global_en_reg  <= 1'b0;
            take_interrupt_reg <= 1'b0;
        end else begin
            int_global_en_reg  <= genable_next;
            take_interrupt_reg <= genable_next && |pend_masked;
        end
    end

    // Byte order swap honoured in user mode only
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            user_swap_active_reg <= 1'b0;
        end else begin
            user_swap_active_reg <= user_next
                && status_next[CTC_USER_SWAP_BIT];
        end
    end

    // Vector select and reduced power follow the stored bits
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            boot_vector_reg   <= 1'b1;
            reduced_power_out <= 1'b0;
        end else begin
            boot_vector_reg   <= status_next[CTC_BOOT_VECTOR_BIT];
            reduced_power_out <= status_next[CTC_REDUCED_POWER_BIT];
        end
    end

    // Coprocessor access; coprocessor 0 forced usable in kernel mode
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cop_access_reg <= 4'h1;
        end else begin
            cop_access_reg <= status_next[CTC_COP_USABLE_LSB +: 4]
                            | {3'h0, kernel_next};
        end
    end

    // Registered read port; unmapped numbers read as zero
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rd_data_reg  <= CTC_ZERO_WORD;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= rd_req.en;
            if (rd_req.en) begin
                unique case (rd_req.num)
                    CTC_REG_COUNT:   rd_data_reg <= count_value;
                    CTC_REG_COMPARE: rd_data_reg <= compare_reg;
                    CTC_REG_STATUS:  rd_data_reg <= status_reg;
                    default:         rd_data_reg <= CTC_ZERO_WORD;
                endcase
            end
        end
    end

endmodule // ctc_timer_status

/* bench/ctc_pipe_model.sv */
// Pipeline side model feeding the pending interrupt lines
`timescale 1ns/1ps
module ctc_pipe_model (
    input  wire logic       timer_irq_out,
    input  wire logic [6:0] sw_pending,
    output logic      [7:0] int_pending
);
    // Timer output alone drives hardware line 5, pending bit 7
    assign int_pending = {timer_irq_out, sw_pending};
endmodule // ctc_pipe_model

/* bench/ctc_timer_status_monitor.sv */
// Port checker for the timer compare and status block
`timescale 1ns/1ps
module ctc_timer_status_monitor (
    input wire logic                 clock,
    input wire logic                 rst_b,
    input wire ctc_pkg::ctc_wr_req_t wr_req,
    input wire ctc_pkg::ctc_rd_req_t rd_req,
    input wire logic                 debug_mode_bit,
    input wire logic                 rd_valid_reg,
    input wire logic                 timer_irq_out,
    input wire logic                 reduced_power_out,
    input wire logic                 int_global_en_reg,
    input wire logic                 take_interrupt_reg,
    input wire logic                 debug_mode_reg,
    input wire logic                 user_mode_reg,
    input wire logic                 kernel_mode_reg,
    input wire logic [3:0]           cop_access_reg,
    input wire logic                 user_swap_active_reg,
    input wire logic                 boot_vector_reg
);
    import ctc_pkg::*;
    logic cmp_wr;
    logic st_wr;
    assign cmp_wr = wr_req.en && (wr_req.num == CTC_REG_COMPARE);
    assign st_wr  = wr_req.en && (wr_req.num == CTC_REG_STATUS);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    a_read_answer_timing: assert property (
        rd_valid_reg == $past(rd_req.en))
        else $error("read valid not one cycle after request");
    a_irq_stays_high: assert property (
        timer_irq_out && !cmp_wr |=> timer_irq_out)
        else $error("timer interrupt dropped without compare write");
    a_irq_clear_cause: assert property (
        $fell(timer_irq_out) |-> $past(cmp_wr))
        else $error("timer interrupt cleared without compare write");
    a_power_on_write: assert property (
        $changed(reduced_power_out) |-> $past(st_wr))
        else $error("reduced power output moved without status write");
    a_boot_vec_write: assert property (
        $fell(boot_vector_reg) |-> $past(st_wr))
        else $error("boot vector select cleared without status write");
    a_mode_one_hot: assert property (
        $onehot({debug_mode_reg, user_mode_reg, kernel_mode_reg}))
        else $error("operating mode outputs not one-hot");
    a_debug_mode_follow: assert property (
        debug_mode_reg == $past(debug_mode_bit))
        else $error("debug mode output does not follow input");
    a_global_en_debug: assert property (
        int_global_en_reg |-> !debug_mode_reg)
        else $error("interrupts enabled in debug mode");
    a_take_needs_en: assert property (
        take_interrupt_reg |-> int_global_en_reg)
        else $error("interrupt taken while globally disabled");
    a_cop0_in_kernel: assert property (
        kernel_mode_reg |-> cop_access_reg[0])
        else $error("coprocessor 0 unusable in kernel mode");
    c_irq_rise: cover property ($rose(timer_irq_out));
    c_take: cover property (take_interrupt_reg);
    c_swap: cover property (user_swap_active_reg);
endmodule // ctc_timer_status_monitor

bind ctc_timer_status ctc_timer_status_monitor u_mon (.clock, .rst_b,
    .wr_req, .rd_req, .debug_mode_bit, .rd_valid_reg, .timer_irq_out,
    .reduced_power_out, .int_global_en_reg, .take_interrupt_reg,
    .debug_mode_reg, .user_mode_reg, .kernel_mode_reg, .cop_access_reg,
    .user_swap_active_reg, .boot_vector_reg);

/* bench/ctc_timer_status_tb_top.sv */
// Self-checking bench for the timer compare and status block
`timescale 1ns/1ps
module ctc_timer_status_tb_top;
    import ctc_pkg::*;
    logic        clock = 1'h0;
    logic        rst_b = 1'h0;
    ctc_wr_req_t wr_req = '0;
    ctc_rd_req_t rd_req = '0;
    ctc_events_t events = '0;
    logic        debug_mode_bit = 1'h0;
    logic [6:0]  sw_pending = 7'h00;
    logic [7:0]  int_pending;
    logic [31:0] rd_data_reg;
    logic [3:0]  cop_access_reg;
    logic        rd_valid_reg, timer_irq_out, reduced_power_out;
    logic        int_global_en_reg, take_interrupt_reg, debug_mode_reg;
    logic        user_mode_reg, kernel_mode_reg, user_swap_active_reg;
    logic        boot_vector_reg;
    logic [31:0] mode_st [6] = '{32'h10, 32'h12, 32'h14, 32'h11, 32'h15,
                                 32'h11};
    logic [4:0]  mode_ex [6] = '{5'h04, 5'h02, 5'h02, 5'h05, 5'h02, 5'h18};
    int          error_cnt = 0;
    int          n_compared = 0;
    int          i;

    always #25 clock = ~clock;

    ctc_timer_status u_dut (.clock, .rst_b, .wr_req, .rd_req, .events,
        .debug_mode_bit, .int_pending, .rd_data_reg, .rd_valid_reg,
        .timer_irq_out, .reduced_power_out, .int_global_en_reg,
        .take_interrupt_reg, .debug_mode_reg, .user_mode_reg,
        .kernel_mode_reg, .cop_access_reg, .user_swap_active_reg,
        .boot_vector_reg);
    ctc_pipe_model u_pipe (.timer_irq_out, .sw_pending, .int_pending);

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [4:0] num, input logic [31:0] data);
        @(posedge clock) #2 wr_req = '{1'h1, num, data};
        @(posedge clock) #2 wr_req.en = 1'h0;
    endtask

    task automatic rd(input logic [4:0] num, input logic [31:0] exp);
        @(posedge clock) #2 rd_req = '{1'h1, num};
        @(posedge clock) #2 rd_req.en = 1'h0;
        chk("rd_data", exp, rd_data_reg);
        chk("rd_valid", 1'h1, rd_valid_reg);
    endtask

    task automatic ev(input ctc_events_t e);
        @(posedge clock) #2 events = e;
        @(posedge clock) #2 events = '0;
    endtask

    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        #(50 * 4000);
        error_cnt++;
        results;
    end

    initial begin
        repeat (10) @(posedge clock);
        #2 rst_b = 1'h1;
        chk("boot_vec", 1'h1, boot_vector_reg);
        rd(CTC_REG_STATUS, 32'h00400004);
        rd(5'h1F, 32'h0);
        wr(CTC_REG_STATUS, 32'hFFFFFFFF);
        rd(CTC_REG_STATUS, 32'hFA60FF17);
        chk("rp_out", 1'h1, reduced_power_out);
        chk("cop", 4'hF, cop_access_reg);
        ev(4'h8);
        rd(CTC_REG_STATUS, 32'hFA70FF17);
        ev(4'h4);
        rd(CTC_REG_STATUS, 32'hFA68FF17);
        wr(CTC_REG_STATUS, 32'hFFFFFFFF);
        rd(CTC_REG_STATUS, 32'hFA68FF17);
        wr(CTC_REG_STATUS, 32'h0);
        chk("rp_off", 1'h0, reduced_power_out);
        ev(4'h2);
        ev(4'h1);
        rd(CTC_REG_STATUS, 32'h00200002);
        for (i = 0; i < 6; i++) begin
            debug_mode_bit = mode_ex[i][4];
            wr(CTC_REG_STATUS, mode_st[i]);
            @(posedge clock) #2;
            chk("mode", mode_ex[i][3:0], {debug_mode_reg, user_mode_reg,
                kernel_mode_reg, int_global_en_reg});
        end
        debug_mode_bit = 1'h0;
        sw_pending = 7'h01;
        wr(CTC_REG_STATUS, 32'h00000101);
        @(posedge clock) #2;
        chk("take", 1'h1, take_interrupt_reg);
        chk("cop0", 4'h1, cop_access_reg);
        wr(CTC_REG_STATUS, 32'h00000201);
        chk("take_off", 1'h0, take_interrupt_reg);
        wr(CTC_REG_STATUS, 32'hE2000010);
        chk("cop_user", 4'hE, cop_access_reg);
        chk("swap", 1'h1, user_swap_active_reg);
        wr(CTC_REG_STATUS, 32'h02000000);
        chk("swap_k", 1'h0, user_swap_active_reg);
        wr(CTC_REG_COMPARE, 32'h14);
        wr(CTC_REG_COUNT, 32'h0);
        chk("irq_low", 1'h0, timer_irq_out);
        i = 0;
        while (timer_irq_out !== 1'h1 && i < 60) begin
            @(posedge clock) #2;
            i++;
        end
        chk("irq_delay", 1'h1, i inside {[40:41]});
        rd(CTC_REG_COUNT, 32'h00000015);
        repeat (8) @(posedge clock) #2;
        chk("irq_hold", 1'h1, timer_irq_out);
        rd(CTC_REG_COMPARE, 32'h14);
        wr(CTC_REG_COMPARE, 32'hFFFFFFFF);
        chk("irq_clr", 1'h0, timer_irq_out);
        rd(CTC_REG_COMPARE, 32'hFFFFFFFF);
        results;
    end
endmodule // ctc_timer_status_tb_top
